// *** src/gocfg_top.sv ***
// Setup store and drive logic for the eight general output pins
// (output_pin_a .. output_pin_h are pin indices 0 .. 7)
module gocfg_top #(
  parameter int TICK_CYCLES = gocfg_pkg::TICK_CYCLES  // Clocks per millisecond
) (
  input  wire logic                             sys_clk,           // System clock, 125 MHz
  input  wire logic                             rst_b,             // Async reset, active low
  input  wire gocfg_pkg::gocfg_cmd_t            cmd,               // Command port request
  output gocfg_pkg::gocfg_resp_t                resp,              // Command port answer
  input  wire logic [gocfg_pkg::NUM_CHAN-1:0]   power_good_in,     // Channel power-good
  input  wire logic [gocfg_pkg::NUM_CHAN-1:0]   general_input_line,// Channel general input
  input  wire logic [gocfg_pkg::NUM_CHAN-1:0]   chan_alarm,        // Alarm per alarm-type setting
  input  wire gocfg_pkg::gocfg_alt_t            alt,               // Alternate function lines
  output logic      [gocfg_pkg::NUM_PINS-1:0]   pin_out,           // Pin output value
  output logic      [gocfg_pkg::NUM_PINS-1:0]   pin_oe_n           // Pin enable, low drives
);

  typedef struct packed {
    gocfg_pkg::gocfg_setup_t [gocfg_pkg::NUM_PINS-1:0] setup;
    logic [gocfg_pkg::TICK_W-1:0]                      tick_cnt;
    logic                                              tick;
    gocfg_pkg::gocfg_resp_t                            resp;
    logic [gocfg_pkg::NUM_PINS-1:0]                    pin_out;
    logic [gocfg_pkg::NUM_PINS-1:0]                    pin_oe_n;
    logic [gocfg_pkg::NUM_CHAN-1:0]                    gi_meta;   // First synchroniser stage
    logic [gocfg_pkg::NUM_CHAN-1:0]                    gi_sync;   // Second stage, the only one read
  } gocfg_state_t;

  localparam logic [gocfg_pkg::TICK_W-1:0] TICK_LAST = gocfg_pkg::TICK_W'(TICK_CYCLES - 1);

  gocfg_state_t                   s;
  gocfg_state_t                   next_s;
  logic [gocfg_pkg::NUM_PINS-1:0] raw;
  logic [gocfg_pkg::NUM_PINS-1:0] filt;
  logic [gocfg_pkg::NUM_PINS-1:0] alt_pull;
  logic [gocfg_pkg::NUM_PINS-1:0] alt_hiz;
  logic [gocfg_pkg::NUM_CHAN-1:0] chan_ok;

  // A channel counts as good when its power-good or its synchronised general input is high
  assign chan_ok = power_good_in | s.gi_sync;

  // Alternate functions per pin; two pins just float
  always_comb begin
    alt_pull                      = '0;
    alt_hiz                       = '0;
    alt_pull[3:0]                 = alt.fault_line;
    alt_pull[gocfg_pkg::PIN_SEQ]  = alt.sequencing_line;
    alt_pull[gocfg_pkg::PIN_SYNC] = alt.sync_line;
    alt_hiz[gocfg_pkg::PIN_HIZ0]  = 1'b1;
    alt_hiz[gocfg_pkg::PIN_HIZ1]  = 1'b1;
  end

  // Per pin: raw combined level and its delay filter
  generate
    for (genvar p = 0; p < gocfg_pkg::NUM_PINS; p++) begin : g_pin
      gocfg_pkg::gocfg_setup_t cfg;
      assign cfg = s.setup[p];

      // Unselected channels drop out of the AND and are blocked from the OR;
      // one continuous assignment per bit keeps a single driver on each bit
      assign raw[p] = (cfg.func_sel == gocfg_pkg::GOCFG_FN_AND) ? &(~cfg.chan_sel | chan_ok)      :
                      (cfg.func_sel == gocfg_pkg::GOCFG_FN_OR)  ? |(cfg.chan_sel & chan_alarm) :
                      1'b0;

      gocfg_pin_filter u_filt (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .ms_tick  (s.tick),
        .raw_in   (raw[p]),
        .on_ms    (gocfg_pkg::DELAY_MS[cfg.on_delay]),
        .off_ms   (gocfg_pkg::DELAY_MS[cfg.off_delay]),
        .filt_out (filt[p])
      );
    end
  endgenerate

  // Next state: timebase, command port, pin drive
  always_comb begin
    logic                          hit;
    logic [2:0]                    idx;
    logic [7:0]                    page_off;
    logic                          asserted;
    logic                          level;
    gocfg_pkg::gocfg_setup_t       wcfg;
    hit      = 1'b0;
    idx      = 3'h0;
    page_off = 8'h00;
    asserted = 1'b0;
    level    = 1'b0;
    wcfg     = gocfg_pkg::SETUP_RESET;
    next_s   = s;

    // Millisecond timebase; a full count keeps ticks exact at any period
    if (s.tick_cnt >= TICK_LAST) begin
      next_s.tick_cnt = '0;
      next_s.tick     = 1'b1;
    end else begin
      next_s.tick_cnt = gocfg_pkg::TICK_W'(s.tick_cnt + 1'b1);
      next_s.tick     = 1'b0;
    end

    // General inputs come from pins; two stages before any logic reads them
    next_s.gi_meta = general_input_line;
    next_s.gi_sync = s.gi_meta;

    // Command port: one word per page, answer next cycle, misses read zero
    next_s.resp.ack   = cmd.wr | cmd.rd;
    next_s.resp.rdata = 32'h0000_0000;
    page_off = cmd.page - gocfg_pkg::PAGE_FIRST;
    idx      = page_off[2:0];
    hit      = (cmd.code == gocfg_pkg::CMD_OUTPUT_PIN_SETUP) &&
               (cmd.page >= gocfg_pkg::PAGE_FIRST) &&
               (cmd.page <= gocfg_pkg::PAGE_LAST);
    if (hit && cmd.wr) begin
      wcfg      = gocfg_pkg::gocfg_setup_t'(cmd.wdata);
      wcfg.zero = 3'h0;
      // Writes take effect at once; nothing guards a change under load
      next_s.setup[idx] = wcfg;
    end else if (hit && cmd.rd) begin
      next_s.resp.rdata = s.setup[idx];
    end

    // Pin drive from the current setup of each pin
    for (int p = 0; p < gocfg_pkg::NUM_PINS; p++) begin
      unique case (s.setup[p].func_sel)
        gocfg_pkg::GOCFG_FN_FORCE_ON: asserted = 1'b1;
        gocfg_pkg::GOCFG_FN_AND,
        gocfg_pkg::GOCFG_FN_OR:       asserted = filt[p];
        default:                      asserted = 1'b0;
      endcase
      level = s.setup[p].pin_polarity ? asserted : ~asserted;
      if (s.setup[p].func_sel == gocfg_pkg::GOCFG_FN_ALT) begin
        // Alternate lines are open-drain: pull low or release
        next_s.pin_out[p]  = 1'b0;
        next_s.pin_oe_n[p] = alt_hiz[p] | ~alt_pull[p];
      end else if (s.setup[p].drive_type) begin
        next_s.pin_out[p]  = 1'b0;
        next_s.pin_oe_n[p] = level;
      end else begin
        next_s.pin_out[p]  = level;
        next_s.pin_oe_n[p] = 1'b0;
      end
    end
  end

  // State register; after reset every pin is in alternate mode
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s.setup    <= {gocfg_pkg::NUM_PINS{gocfg_pkg::SETUP_RESET}};
      s.tick_cnt <= '0;
      s.tick     <= 1'b0;
      s.gi_meta  <= '0;
      s.gi_sync  <= '0;
      s.resp     <= '0;
      s.pin_out  <= '0;
      s.pin_oe_n <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign resp     = s.resp;
  assign pin_out  = s.pin_out;
  assign pin_oe_n = s.pin_oe_n;

endmodule : gocfg_top

// *** inc/gocfg_pkg.sv ***
// What this block does
// - Select 000 drives the pin's alternate function: fault, sequencing, high-Z, sync.
// - Select 001 holds the pin asserted, honouring its polarity.
// - Select 010 holds the pin deasserted, honouring its polarity.
// - Select 011 asserts when every selected channel's power-good or input is asserted.
// - Bits 31:16 select channels, channel N at bit N plus 16.
// - Select 100 asserts when any selected channel alarm is active.
// - Each pin has its own polarity and push-pull or open-drain choice.
// - Pages 21 to 28 each address one pin's own setup word.
// - Alarm used in OR mode follows each channel's alarm-type setting.
// - Drive-type bit 7: 0 push-pull, 1 open-drain.
// - Polarity bit 6: 0 active low, 1 active high; bits 5:3 read zero.
// - Pin changes only after input stays unchanged for the whole delay.
// - Delays apply only in AND and OR modes, not forced or alternate.
package gocfg_pkg;

  localparam int NUM_PINS = 8;
  localparam int NUM_CHAN = 16;
  localparam int DLY_W    = 12;
  localparam int TICK_W   = 20;

  // Command decode
  localparam logic [7:0] CMD_OUTPUT_PIN_SETUP = 8'hF8;
  localparam logic [7:0] PAGE_FIRST           = 8'h15;
  localparam logic [7:0] PAGE_LAST            = 8'h1C;

  // Timebase
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;

  // Pin positions with fixed alternate functions
  localparam int PIN_SEQ  = 4;
  localparam int PIN_HIZ0 = 5;
  localparam int PIN_HIZ1 = 6;
  localparam int PIN_SYNC = 7;

  // Delay code to milliseconds, entry 0 first from the right
  localparam logic [15:0][DLY_W-1:0] DELAY_MS = {
    12'hFA0, 12'h7D0, 12'h5DC, 12'h3E8, 12'h320, 12'h258, 12'h190, 12'h0C8,
    12'h064, 12'h050, 12'h03C, 12'h028, 12'h014, 12'h00A, 12'h005, 12'h000
  };

  typedef enum logic [2:0] {
    GOCFG_FN_ALT       = 3'h0,
    GOCFG_FN_FORCE_ON  = 3'h1,
    GOCFG_FN_FORCE_OFF = 3'h2,
    GOCFG_FN_AND       = 3'h3,
    GOCFG_FN_OR        = 3'h4,
    GOCFG_FN_RSV5      = 3'h5,
    GOCFG_FN_RSV6      = 3'h6,
    GOCFG_FN_RSV7      = 3'h7
  } gocfg_func_t;

  // One output_pin_setup word
  typedef struct packed {
    logic [15:0] chan_sel;     // 31:16
    logic [3:0]  off_delay;    // 15:12
    logic [3:0]  on_delay;     // 11:8
    logic        drive_type;   // 7
    logic        pin_polarity; // 6
    logic [2:0]  zero;         // 5:3
    gocfg_func_t func_sel;     // 2:0
  } gocfg_setup_t;

  localparam gocfg_setup_t SETUP_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [7:0]  page;
    logic [7:0]  code;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } gocfg_cmd_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } gocfg_resp_t;

  // Alternate function lines, each high when that function pulls its pin low
  typedef struct packed {
    logic       sync_line;
    logic       sequencing_line;
    logic [3:0] fault_line;  // fault_line_zero .. fault_line_three
  } gocfg_alt_t;

  typedef struct packed {
    logic             level;
    logic [DLY_W-1:0] cnt;
  } gocfg_filt_t;

  localparam gocfg_filt_t FILT_RESET = 13'h0000;

endpackage : gocfg_pkg

// *** src/gocfg_pin_filter.sv ***
// Holds a pin's logical level until a change has lasted the whole delay
module gocfg_pin_filter (
  input  wire logic                        sys_clk,  // System clock
  input  wire logic                        rst_b,    // Async reset
  input  wire logic                        ms_tick,  // One-cycle millisecond tick
  input  wire logic                        raw_in,   // Unfiltered logical level
  input  wire logic [gocfg_pkg::DLY_W-1:0] on_ms,    // Assertion delay
  input  wire logic [gocfg_pkg::DLY_W-1:0] off_ms,   // Deassertion delay
  output logic                             filt_out  // Filtered level
);

  gocfg_pkg::gocfg_filt_t s;
  gocfg_pkg::gocfg_filt_t next_s;

  // Count whole ticks of a steady differing input; return to agreement restarts
  always_comb begin
    next_s = s;
    if (ms_tick) begin
      if (raw_in == s.level) begin
        next_s.cnt = '0;
      end else if (s.cnt >= (raw_in ? on_ms : off_ms)) begin
        next_s.level = raw_in;
        next_s.cnt   = '0;
      end else begin
        next_s.cnt = gocfg_pkg::DLY_W'(s.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= gocfg_pkg::FILT_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign filt_out = s.level;

endmodule : gocfg_pin_filter

// *** tb/gocfg_board.sv ***
// Board side of the pins: pull-ups on every pin, consumers read the pad
module gocfg_board (
  input  wire logic [7:0] pin_out,  // Driven value
  input  wire logic [7:0] pin_oe_n, // Enable, low drives
  output logic      [7:0] pad       // Resolved pad level
);
  timeunit 1ns;
  timeprecision 100ps;
  // Released pins rise through the pull-up, so a float never reads as low
  assign pad = pin_out | pin_oe_n;
endmodule : gocfg_board

// *** tb/gocfg_top_sva.sv ***
module gocfg_top_sva #(
  parameter int TICK_CYCLES = gocfg_pkg::TICK_CYCLES  // Clocks per millisecond
) (
  input wire logic                   sys_clk,  // Clock
  input wire logic                   rst_b,    // Reset, active low
  input wire gocfg_pkg::gocfg_cmd_t  cmd,      // Request
  input wire gocfg_pkg::gocfg_resp_t resp,     // Answer
  input wire gocfg_pkg::gocfg_alt_t  alt,      // Alternate lines
  input wire logic [7:0]             pin_out,  // Pin value
  input wire logic [7:0]             pin_oe_n  // Pin enable
);
  gocfg_pkg::gocfg_setup_t [7:0] sh;
  logic                          quiet;
  logic                          hit;
  logic [7:0]                    fz;
  logic [7:0]                    lv;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Address decode of the one setup command
  assign hit = cmd.code == gocfg_pkg::CMD_OUTPUT_PIN_SETUP && cmd.page >= gocfg_pkg::PAGE_FIRST
               && cmd.page <= gocfg_pkg::PAGE_LAST;
  // Shadow of the setup words; quiet until the first accepted write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh    <= '0;
      quiet <= 1'b1;
    end else if (cmd.wr && hit) begin
      sh[3'(cmd.page - gocfg_pkg::PAGE_FIRST)] <= cmd.wdata;
      quiet                                    <= 1'b0;
    end
  end
  // Forced modes and the level they imply
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      fz[i] = sh[i].func_sel inside {gocfg_pkg::GOCFG_FN_FORCE_ON, gocfg_pkg::GOCFG_FN_FORCE_OFF};
      lv[i] = sh[i].pin_polarity ^ (sh[i].func_sel == gocfg_pkg::GOCFG_FN_FORCE_OFF);
    end
  end
  sequence s_req;
    cmd.wr || cmd.rd;
  endsequence
  sequence s_bad_rd;
    cmd.rd && (cmd.wr || !hit);
  endsequence
  a_ack_follows_req : assert property (s_req |=> resp.ack) else $error("ack missing");
  a_ack_has_cause : assert property (resp.ack |-> $past(cmd.wr || cmd.rd)) else $error("ack unasked");
  a_rdata_idle_zero : assert property (!resp.ack |-> resp.rdata == 32'h0) else $error("rdata idle");
  a_miss_reads_zero : assert property (s_bad_rd |=> resp.rdata == 32'h0) else $error("miss data");
  a_spare_bits_zero : assert property (cmd.rd |=> resp.rdata[5:3] == 3'h0) else $error("bits 5:3");
  a_never_float_high : assert property ((pin_out & pin_oe_n) == 8'h00) else $error("float high");
  a_alt_drive_reset : assert property (quiet |=> pin_out == 8'h00 && pin_oe_n == ~{$past(alt.sync_line),
    2'h0, $past(alt.sequencing_line), $past(alt.fault_line)}) else $error("alternate drive");
  for (genvar i = 0; i < 8; i++) begin : g_pin
    a_force_level : assert property (fz[i] |=> pin_oe_n[i] == ($past(sh[i].drive_type) & $past(lv[i]))
      && pin_out[i] == (!$past(sh[i].drive_type) & $past(lv[i]))) else $error("forced level");
  end
endmodule : gocfg_top_sva

bind gocfg_top gocfg_top_sva #(.TICK_CYCLES(TICK_CYCLES)) u_gocfg_top_sva (.sys_clk(sys_clk), .rst_b(rst_b),
  .cmd(cmd), .resp(resp), .alt(alt), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// *** tb/gocfg_bench.sv ***
module gocfg_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int T = 4;
  logic                   sys_clk;
  logic                   rst_b;
  gocfg_pkg::gocfg_cmd_t  cmd;
  gocfg_pkg::gocfg_resp_t resp;
  logic [15:0]            power_good_in;
  logic [15:0]            general_input_line;
  logic [15:0]            chan_alarm;
  gocfg_pkg::gocfg_alt_t  alt;
  logic [7:0]             pin_out;
  logic [7:0]             pin_oe_n;
  logic [7:0]             pad;
  logic [31:0]            q;
  logic                   lvl;
  int                     mismatches;
  int                     comparisons;
  int                     cycles;
  gocfg_top #(.TICK_CYCLES(T)) u_gocfg_top (.sys_clk(sys_clk), .rst_b(rst_b), .cmd(cmd), .resp(resp),
    .power_good_in(power_good_in), .general_input_line(general_input_line), .chan_alarm(chan_alarm),
    .alt(alt), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  gocfg_board u_gocfg_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pad(pad));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tk
  // One request held for one edge; the answer stands in the following cycle
  task automatic acc(input logic w, input logic [7:0] pg, input logic [7:0] cd, input logic [31:0] d);
    tk(1);
    cmd = '{page: pg, code: cd, wr: w, rd: !w, wdata: d};
    tk(1);
    cmd.wr = 1'b0;
    cmd.rd = 1'b0;
    chk(32'(resp.ack), 32'h1);
    q = resp.rdata;
  endtask : acc
  // Bounded wait for a pad level, then compare
  task automatic wt(input int b, input logic v);
    for (int n = 0; n < 4 * T && pad[b] !== v; n++) tk(1);
    chk(32'(pad[b]), 32'(v));
  endtask : wt
  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  // Free-running clock, 8 ns period
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Hang guard, far above the expected run of under two hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end
  // Main sequence; supplies stay off while setups change
  initial begin
    rst_b = 1'b0;
    cmd = '0;
    power_good_in = 16'h0000;
    general_input_line = 16'h0000;
    chan_alarm = 16'h0000;
    alt = 6'h01;
    repeat (12) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    tk(2);
    chk(32'(pad), 32'hFE);
    acc(1'b0, 8'h15, 8'hF8, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 8; i++) acc(1'b1, 8'(8'h15 + i), 8'hF8, {12'(i + 1), 20'h00038});
    for (int i = 0; i < 8; i++) begin
      acc(1'b0, 8'(8'h15 + i), 8'hF8, 32'h0);
      chk(q, {12'(i + 1), 20'h0});
    end
    acc(1'b1, 8'h1D, 8'hF8, 32'hFFFF_FFFF);
    acc(1'b1, 8'h1C, 8'hF0, 32'hFFFF_FFFF);
    acc(1'b0, 8'h1C, 8'hF8, 32'h0);
    chk(q, 32'h0080_0000);
    acc(1'b0, 8'h14, 8'hF8, 32'h0);
    chk(q, 32'h0);
    // Sync, sequencing and fault line one pull pins 7, 4 and 1; the floating pair stays high
    alt = 6'h32;
    tk(2);
    chk(32'(pad), 32'h6D);
    // Forced levels ignore the long delays and follow polarity and drive type
    for (int k = 0; k < 8; k++) begin
      acc(1'b1, 8'h17, 8'hF8, {16'h0, 8'hFF, k[1], k[0], 3'h0, k[2] ? 3'h2 : 3'h1});
      tk(1);
      lvl = k[0] ^ k[2];
      chk(32'(pad[2]), 32'(lvl));
      chk(32'(pin_oe_n[2]), 32'(k[1] & lvl));
    end
    // Reserved select codes fall back to the deasserted level
    acc(1'b1, 8'h17, 8'hF8, 32'h0000_0045);
    tk(1);
    chk(32'(pad[2]), 32'h0);
    // AND of channels 0 and 3, 5 ms assert delay with a glitch that restarts it
    acc(1'b1, 8'h15, 8'hF8, {16'h0009, 4'h0, 4'h1, 8'h43});
    power_good_in[0] = 1'b1;
    general_input_line[3] = 1'b1;
    tk(3 * T);
    power_good_in[0] = 1'b0;
    tk(T);
    power_good_in[0] = 1'b1;
    tk(5 * T);
    chk(32'(pad[0]), 32'h0);
    wt(0, 1'b1);
    power_good_in[0] = 1'b0;
    wt(0, 1'b0);
    // OR of channel 15 alarm only, active low, open drain
    acc(1'b1, 8'h16, 8'hF8, {16'h8000, 8'h00, 8'h84});
    chan_alarm[14] = 1'b1;
    tk(3 * T);
    chk(32'(pad[1]), 32'h1);
    chan_alarm[15] = 1'b1;
    wt(1, 1'b0);
    chk(32'(pin_oe_n[1]), 32'h0);
    conclude();
  end
endmodule : gocfg_bench
